// file: bscfg_cap_if.sv
// Interface between the top and one strap capture group
`timescale 1ns/10ps
interface bscfg_cap_if #(parameter int W = 1);
	logic qual;
	logic [W-1:0] pins;
	logic [W-1:0] value;
	logic [W-1:0] pd_en;
	logic normal;
	modport cap(input qual, input pins, output value, output pd_en, output normal);
	modport user(output qual, output pins, input value, input pd_en, input normal);
endinterface : bscfg_cap_if

// file: bscfg_capture.sv
// Edge-qualified strap capture for one group of pins
`timescale 1ns/10ps
module bscfg_capture #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Capture group
	bscfg_cap_if.cap cif
);
	logic qual_d_ff, nxt_qual_d;
	logic [W-1:0] value_ff, nxt_value;
	logic [W-1:0] pd_en_ff, nxt_pd_en;
	logic normal_ff, nxt_normal;
	logic rise;

	assign rise = cif.qual & ~qual_d_ff;

	always_comb begin
		nxt_qual_d = cif.qual;
		nxt_value = rise ? cif.pins : value_ff;
		nxt_pd_en = cif.qual ? '0 : '1;
		nxt_normal = cif.qual;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			qual_d_ff <= 1'b0;
			value_ff <= '0;
			pd_en_ff <= '1;
			normal_ff <= 1'b0;
		end else begin
			qual_d_ff <= nxt_qual_d;
			value_ff <= nxt_value;
			pd_en_ff <= nxt_pd_en;
			normal_ff <= nxt_normal;
		end
	end

	assign cif.value = value_ff;
	assign cif.pd_en = pd_en_ff;
	assign cif.normal = normal_ff;

	a_capture_edge: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(cif.qual && !qual_d_ff) |=> (value_ff == $past(cif.pins)))
		else $error("strap not captured on qualifier edge");
	a_hold_value: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!(cif.qual && !qual_d_ff) |=> $stable(value_ff))
		else $error("strap value changed without sampling event");
	a_pulldown_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		cif.qual [*2] |-> (pd_en_ff == '0) && normal_ff)
		else $error("pull-down still on after qualifier high");
endmodule : bscfg_capture

// file: bscfg_flash_model.sv
// Serial flash model that answers the soft-strap fetch
`timescale 1ns/10ps
module bscfg_flash_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Answer latency (at least 1) and block size held in word 0
	input wire logic [3:0] lat_i,
	input wire logic [2:0] blk_i,
	// Flash port
	input wire logic flash_req_i,
	input wire logic [23:0] flash_addr_i,
	output logic [31:0] flash_rdata_o,
	output logic flash_rvalid_o
);
	logic [3:0] cnt_ff;
	logic [23:0] addr_ff;
	initial begin
		flash_rdata_o = 32'h5A5A_5A5A;
		flash_rvalid_o = 1'b0;
		cnt_ff = 4'h0;
		addr_ff = 24'h000000;
	end
	always @(posedge core_clk_i) begin
		flash_rvalid_o <= 1'b0;
		// Idle data flips every cycle so a stale word never passes
		flash_rdata_o <= ~flash_rdata_o;
		if (!rstn_i) begin
			cnt_ff <= 4'h0;
		end else if (flash_req_i) begin
			cnt_ff <= lat_i;
			addr_ff <= flash_addr_i;
		end else if (cnt_ff == 4'h1) begin
			flash_rvalid_o <= 1'b1;
			flash_rdata_o <= {addr_ff, 5'h00, blk_i};
			cnt_ff <= 4'h0;
		end else if (cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule : bscfg_flash_model

// file: bscfg_pkg.sv
// Constants shared by the strap sampling and boot configuration block
//------------------------------------------------------------------
// What this block does
// - Capture each strap on its qualifier's rising edge, then release the pin
// - Fetch soft straps from flash before releasing engine and host resets
// - Forced swap inverts A16, or the bit picked by block-size soft strap
// - While the swap strap forces swapping, software cannot clear the swap bit
// - Swap state is readable at bit 4 of offset DCh
// - Strap pull-down turns off once its qualifier is high
// - No-reboot strap at 1 blocks watchdog system reboot
// - Transport strap, latched at resume reset release, enables encrypted transport
// - Codes 0000 and 0010 select host-attached flash, enhanced interface on or off
// - Code 0100 host firmware on peripheral channel; 1000 all behind target
// - Code 1100 host on peripheral channel, engine on target flash; rest reserved
// - Swap bit cleared by real-time-clock well reset, not platform reset
//------------------------------------------------------------------
package bscfg_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_SWAP_OFS = 8'hDC;
	localparam logic [7:0] REG_STAT_OFS = 8'hE0;
	localparam logic [7:0] REG_SOFT_OFS = 8'hE4;
	localparam int SWAP_BIT = 4;
	localparam int STAT_NO_REBOOT = 0;
	localparam int STAT_TRANSPORT = 1;
	localparam int STAT_BOOT_LSB = 2;
	localparam int STAT_FETCH_DONE = 6;
	localparam int STAT_SWAP_STRAP = 7;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	// ------------------------------------------------------------
	// Soft straps and address swap
	// ------------------------------------------------------------
	localparam int SOFT_WORDS = 4;
	localparam logic [23:0] SOFT_BASE = 24'h000000;
	localparam int BLK_SIZE_W = 3;
	localparam logic [2:0] BLK_SIZE_RST = 3'h0;
	localparam int SWAP_LOW_BIT = 16;
	localparam int FLASH_AW = 24;
	// ------------------------------------------------------------
	// Boot codes and strap groups
	// ------------------------------------------------------------
	localparam logic [3:0] BOOT_HOST_ESPI_ON = 4'h0;
	localparam logic [3:0] BOOT_HOST_ESPI_OFF = 4'h2;
	localparam logic [3:0] BOOT_PERIPH_HOST = 4'h4;
	localparam logic [3:0] BOOT_TARGET_ALL = 4'h8;
	localparam logic [3:0] BOOT_PERIPH_TARGET = 4'hC;
	localparam int CORE_STRAPS = 2;
	localparam int RESUME_STRAPS = 5;
	localparam int NUM_STRAPS = CORE_STRAPS + RESUME_STRAPS;
	typedef enum logic [1:0] {F_WAIT, F_REQ, F_RESP, F_DONE} bscfg_fetch_t;
endpackage : bscfg_pkg

// file: bscfg_top.sv
// Strap sampling, soft-strap fetch, boot swap and boot code decode
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module bscfg_top #(
	parameter int N_SOFT = bscfg_pkg::SOFT_WORDS,
	parameter logic [23:0] SOFT_ADDR = bscfg_pkg::SOFT_BASE
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Power and reset qualifiers
	input wire logic deep_sleep_power_good_i,
	input wire logic resume_reset_n_i,
	input wire logic core_power_good_i,
	input wire logic rtc_well_reset_n_i,
	input wire logic platform_reset_n_i,
	// Strap pins
	input wire logic swap_override_strap_pin_i,
	input wire logic no_reboot_strap_pin_i,
	input wire logic transport_security_strap_pin_i,
	input wire logic boot_code_bit0_pin_i,
	input wire logic boot_code_bit1_pin_i,
	input wire logic boot_code_bit2_pin_i,
	input wire logic boot_code_bit3_pin_i,
	// Pin control
	output logic [bscfg_pkg::NUM_STRAPS-1:0] strap_pulldown_en_o,
	output logic [bscfg_pkg::NUM_STRAPS-1:0] strap_pin_normal_o,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// Flash access
	input wire logic host_req_i,
	input wire logic [bscfg_pkg::FLASH_AW-1:0] host_addr_i,
	output logic flash_req_o,
	output logic [bscfg_pkg::FLASH_AW-1:0] flash_addr_o,
	input wire logic [31:0] flash_rdata_i,
	input wire logic flash_rvalid_i,
	// Downstream resets
	output logic security_engine_reset_n_o,
	output logic host_reset_n_o,
	// Watchdog
	input wire logic watchdog_timer_expire_i,
	output logic system_reboot_o,
	// Configuration outputs
	output logic encrypted_transport_en_o,
	output logic [3:0] boot_code_o,
	output logic espi_enable_o,
	output logic host_fw_periph_o,
	output logic se_fw_target_o,
	output logic flash_target_attached_o,
	output logic boot_code_reserved_o
);
	import bscfg_pkg::*;

	// ------------------------------------------------------------
	// Strap capture groups
	// ------------------------------------------------------------
	bscfg_cap_if #(.W(CORE_STRAPS)) core_if();
	bscfg_cap_if #(.W(RESUME_STRAPS)) resume_if();

	assign core_if.qual = core_power_good_i;
	assign core_if.pins = {no_reboot_strap_pin_i, swap_override_strap_pin_i};
	assign resume_if.qual = resume_reset_n_i;
	assign resume_if.pins = {boot_code_bit3_pin_i, boot_code_bit2_pin_i, boot_code_bit1_pin_i,
		boot_code_bit0_pin_i, transport_security_strap_pin_i};

	bscfg_capture #(.W(CORE_STRAPS)) u_core_cap (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.cif(core_if.cap)
	);
	bscfg_capture #(.W(RESUME_STRAPS)) u_resume_cap (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.cif(resume_if.cap)
	);

	logic swap_strap, no_reboot_strap, transport_strap;
	logic [3:0] boot_strap;
	assign swap_strap = core_if.value[0];
	assign no_reboot_strap = core_if.value[1];
	assign transport_strap = resume_if.value[0];
	assign boot_strap = resume_if.value[4:1];
	assign strap_pulldown_en_o = {resume_if.pd_en, core_if.pd_en};
	assign strap_pin_normal_o = {{RESUME_STRAPS{resume_if.normal}}, {CORE_STRAPS{core_if.normal}}};

	// ------------------------------------------------------------
	// Swap address function
	// ------------------------------------------------------------
	// Only the top two blocks trade places; all else passes unchanged
	function automatic logic [FLASH_AW-1:0] bscfg_swap(input logic [FLASH_AW-1:0] a,
		input logic [BLK_SIZE_W-1:0] sz);
		logic [FLASH_AW-1:0] r;
		logic top;
		int b;
		r = a;
		top = 1'b1;
		b = SWAP_LOW_BIT + int'(sz);
		for (int i = SWAP_LOW_BIT; i < FLASH_AW; i++) begin
			if (i > b && !a[i]) begin
				top = 1'b0;
			end
		end
		if (top) begin
			r[b] = ~a[b];
		end
		return r;
	endfunction : bscfg_swap

	// ------------------------------------------------------------
	// Soft-strap fetch
	// ------------------------------------------------------------
	localparam int IDX_W = (N_SOFT > 1) ? $clog2(N_SOFT) : 1;
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(N_SOFT - 1);

	bscfg_fetch_t fstate_ff, nxt_fstate;
	logic [IDX_W-1:0] idx_ff, nxt_idx;
	logic [31:0] soft_ff [N_SOFT];
	logic [31:0] nxt_soft [N_SOFT];
	logic [BLK_SIZE_W-1:0] blk_size_ff, nxt_blk_size;
	logic flash_req_ff, nxt_flash_req;
	logic [FLASH_AW-1:0] flash_addr_ff, nxt_flash_addr;
	logic se_rst_n_ff, nxt_se_rst_n;
	logic host_rst_n_ff, nxt_host_rst_n;
	logic swap_ff, nxt_swap;

	always_comb begin
		nxt_fstate = fstate_ff;
		nxt_idx = idx_ff;
		nxt_soft = soft_ff;
		nxt_blk_size = blk_size_ff;
		nxt_flash_req = 1'b0;
		nxt_flash_addr = flash_addr_ff;
		case (fstate_ff)
			F_WAIT: begin
				nxt_idx = '0;
				if (resume_if.normal && deep_sleep_power_good_i) begin
					nxt_fstate = F_REQ;
				end
			end
			F_REQ: begin
				nxt_flash_req = 1'b1;
				nxt_flash_addr = SOFT_ADDR + FLASH_AW'({idx_ff, 2'b00});
				nxt_fstate = F_RESP;
			end
			F_RESP: begin
				if (flash_rvalid_i) begin
					nxt_soft[idx_ff] = flash_rdata_i;
					if (idx_ff == '0) begin
						nxt_blk_size = flash_rdata_i[BLK_SIZE_W-1:0];
					end
					if (idx_ff == IDX_LAST) begin
						nxt_fstate = F_DONE;
					end else begin
						nxt_idx = idx_ff + IDX_W'(1);
						nxt_fstate = F_REQ;
					end
				end
			end
			F_DONE: begin
				// Host traffic only once the soft straps are in place
				if (host_req_i) begin
					nxt_flash_req = 1'b1;
					nxt_flash_addr = swap_ff ? bscfg_swap(host_addr_i, blk_size_ff) : host_addr_i;
				end
			end
			default: begin
				nxt_fstate = F_WAIT;
			end
		endcase
		if (!resume_reset_n_i) begin
			nxt_fstate = F_WAIT;
		end
		nxt_se_rst_n = (fstate_ff == F_DONE) && resume_reset_n_i;
		nxt_host_rst_n = (fstate_ff == F_DONE) && resume_reset_n_i && core_if.normal
			&& platform_reset_n_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			fstate_ff <= F_WAIT;
			idx_ff <= '0;
			for (int i = 0; i < N_SOFT; i++) begin
				soft_ff[i] <= 32'h0000_0000;
			end
			blk_size_ff <= BLK_SIZE_RST;
			flash_req_ff <= 1'b0;
			flash_addr_ff <= '0;
			se_rst_n_ff <= 1'b0;
			host_rst_n_ff <= 1'b0;
		end else begin
			fstate_ff <= nxt_fstate;
			idx_ff <= nxt_idx;
			soft_ff <= nxt_soft;
			blk_size_ff <= nxt_blk_size;
			flash_req_ff <= nxt_flash_req;
			flash_addr_ff <= nxt_flash_addr;
			se_rst_n_ff <= nxt_se_rst_n;
			host_rst_n_ff <= nxt_host_rst_n;
		end
	end

	assign flash_req_o = flash_req_ff;
	assign flash_addr_o = flash_addr_ff;
	assign security_engine_reset_n_o = se_rst_n_ff;
	assign host_reset_n_o = host_rst_n_ff;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_swap = swap_ff;
		if (reg_we_i && reg_addr_i == REG_SWAP_OFS) begin
			nxt_swap = reg_wdata_i[SWAP_BIT];
		end
		if (swap_strap) begin
			nxt_swap = 1'b1;
		end
		nxt_rdata = RDATA_RST;
		if (reg_re_i) begin
			if (reg_addr_i == REG_SWAP_OFS) begin
				nxt_rdata[SWAP_BIT] = swap_ff;
			end else if (reg_addr_i == REG_STAT_OFS) begin
				nxt_rdata[STAT_NO_REBOOT] = no_reboot_strap;
				nxt_rdata[STAT_TRANSPORT] = transport_strap;
				nxt_rdata[STAT_BOOT_LSB +: 4] = boot_strap;
				nxt_rdata[STAT_FETCH_DONE] = (fstate_ff == F_DONE);
				nxt_rdata[STAT_SWAP_STRAP] = swap_strap;
			end else begin
				for (int i = 0; i < N_SOFT; i++) begin
					if (reg_addr_i == REG_SOFT_OFS + 8'(4 * i)) begin
						nxt_rdata = soft_ff[i];
					end
				end
			end
		end
	end

	// Kept through platform reset so a failed update still boots
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || !rtc_well_reset_n_i) begin
			swap_ff <= 1'b0;
		end else begin
			swap_ff <= nxt_swap;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rdata_ff <= RDATA_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ------------------------------------------------------------
	// Watchdog gate and boot decode
	// ------------------------------------------------------------
	logic reboot_ff, nxt_reboot;
	logic xport_ff, nxt_xport;
	logic [3:0] code_ff, nxt_code;
	logic espi_ff, nxt_espi;
	logic periph_ff, nxt_periph;
	logic se_tgt_ff, nxt_se_tgt;
	logic tgt_ff, nxt_tgt;
	logic rsvd_ff, nxt_rsvd;

	always_comb begin
		nxt_reboot = watchdog_timer_expire_i && !no_reboot_strap;
		nxt_xport = transport_strap;
		nxt_code = boot_strap;
		nxt_espi = 1'b0;
		nxt_periph = 1'b0;
		nxt_se_tgt = 1'b0;
		nxt_tgt = 1'b0;
		nxt_rsvd = 1'b0;
		case (boot_strap)
			BOOT_HOST_ESPI_ON: begin
				nxt_espi = 1'b1;
			end
			BOOT_HOST_ESPI_OFF: begin
				nxt_espi = 1'b0;
			end
			BOOT_PERIPH_HOST: begin
				nxt_espi = 1'b1;
				nxt_periph = 1'b1;
			end
			BOOT_TARGET_ALL: begin
				nxt_espi = 1'b1;
				nxt_tgt = 1'b1;
				nxt_se_tgt = 1'b1;
			end
			BOOT_PERIPH_TARGET: begin
				nxt_espi = 1'b1;
				nxt_periph = 1'b1;
				nxt_se_tgt = 1'b1;
			end
			default: begin
				nxt_rsvd = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			reboot_ff <= 1'b0;
			xport_ff <= 1'b0;
			code_ff <= 4'h0;
			espi_ff <= 1'b0;
			periph_ff <= 1'b0;
			se_tgt_ff <= 1'b0;
			tgt_ff <= 1'b0;
			rsvd_ff <= 1'b0;
		end else begin
			reboot_ff <= nxt_reboot;
			xport_ff <= nxt_xport;
			code_ff <= nxt_code;
			espi_ff <= nxt_espi;
			periph_ff <= nxt_periph;
			se_tgt_ff <= nxt_se_tgt;
			tgt_ff <= nxt_tgt;
			rsvd_ff <= nxt_rsvd;
		end
	end

	assign system_reboot_o = reboot_ff;
	assign encrypted_transport_en_o = xport_ff;
	assign boot_code_o = code_ff;
	assign espi_enable_o = espi_ff;
	assign host_fw_periph_o = periph_ff;
	assign se_fw_target_o = se_tgt_ff;
	assign flash_target_attached_o = tgt_ff;
	assign boot_code_reserved_o = rsvd_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	a_reset_after_fetch: assert property (security_engine_reset_n_o || host_reset_n_o |->
		$past(fstate_ff) == F_DONE)
		else $error("reset released before soft straps fetched");
	a_swap_addr: assert property ((fstate_ff == F_DONE) && host_req_i && resume_reset_n_i
		&& !swap_ff |=> flash_req_o && flash_addr_o == $past(host_addr_i))
		else $error("address altered while swap off");
	a_swap_bit16: assert property ((fstate_ff == F_DONE) && host_req_i && resume_reset_n_i
		&& swap_ff && blk_size_ff == 3'h0 && host_addr_i[23:17] == 7'h7F
		|=> flash_addr_o == ($past(host_addr_i) ^ 24'h010000))
		else $error("bit 16 not inverted");
	a_swap_sticky: assert property (swap_strap && rtc_well_reset_n_i |=> swap_ff)
		else $error("swap bit cleared while strap forces it");
	a_swap_read: assert property (reg_re_i && reg_addr_i == REG_SWAP_OFS
		|=> reg_rdata_o[SWAP_BIT] == $past(swap_ff))
		else $error("swap bit read mismatch");
	a_no_reboot: assert property (watchdog_timer_expire_i && no_reboot_strap |=> !system_reboot_o)
		else $error("watchdog reboot not blocked");
	a_transport_en: assert property (1'b1 |=> encrypted_transport_en_o == $past(transport_strap))
		else $error("transport enable mismatch");
	a_boot_code: assert property (1'b1 |=> boot_code_o == $past(boot_strap))
		else $error("boot code mismatch");
	a_espi_off: assert property (boot_code_o == BOOT_HOST_ESPI_OFF |-> !espi_enable_o
		&& !boot_code_reserved_o)
		else $error("code 0010 decoded wrong");
	a_reserved_code: assert property (boot_code_o == 4'h1 |-> boot_code_reserved_o && !espi_enable_o)
		else $error("reserved code not flagged");
	a_rtc_clear: assert property (!rtc_well_reset_n_i |=> !swap_ff)
		else $error("swap bit survived rtc well reset");
endmodule : bscfg_top

// file: tb_bscfg_top.sv
// Self-checking testbench for the strap sampling block
`timescale 1ns/10ps
module tb_bscfg_top;
	import bscfg_pkg::*;
	localparam logic [23:0] SADDR = 24'h000100;
	localparam logic [3:0] CODES [8] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hC, 4'h1, 4'h7, 4'hF};
	logic core_clk_i, rstn_i, deep_sleep_power_good_i, resume_reset_n_i, core_power_good_i;
	logic rtc_well_reset_n_i, platform_reset_n_i, swap_override_strap_pin_i, no_reboot_strap_pin_i;
	logic transport_security_strap_pin_i, boot_code_bit0_pin_i, boot_code_bit1_pin_i;
	logic boot_code_bit2_pin_i, boot_code_bit3_pin_i, reg_we_i, reg_re_i, host_req_i, flash_req_o;
	logic flash_rvalid_i, security_engine_reset_n_o, host_reset_n_o, watchdog_timer_expire_i;
	logic system_reboot_o, encrypted_transport_en_o, espi_enable_o, host_fw_periph_o, se_fw_target_o;
	logic flash_target_attached_o, boot_code_reserved_o, rd_due, swap_bit, st_swap, st_nrb, tr, vld;
	logic [6:0] strap_pulldown_en_o, strap_pin_normal_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, flash_rdata_i, seed, r;
	logic [23:0] host_addr_i, flash_addr_o, a;
	logic [3:0] boot_code_o, lat_m, code;
	logic [2:0] blk_m;
	logic [31:0] exp_rd[$];
	logic [31:0] exp_fa[$];
	int n_mismatch, num_checks, n_rv;
	bscfg_top #(.N_SOFT(SOFT_WORDS), .SOFT_ADDR(SADDR)) uut (.core_clk_i, .rstn_i, .deep_sleep_power_good_i,
		.resume_reset_n_i, .core_power_good_i, .rtc_well_reset_n_i, .platform_reset_n_i,
		.swap_override_strap_pin_i, .no_reboot_strap_pin_i, .transport_security_strap_pin_i,
		.boot_code_bit0_pin_i, .boot_code_bit1_pin_i, .boot_code_bit2_pin_i, .boot_code_bit3_pin_i,
		.strap_pulldown_en_o, .strap_pin_normal_o, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
		.reg_rdata_o, .host_req_i, .host_addr_i, .flash_req_o, .flash_addr_o, .flash_rdata_i,
		.flash_rvalid_i, .security_engine_reset_n_o, .host_reset_n_o, .watchdog_timer_expire_i,
		.system_reboot_o, .encrypted_transport_en_o, .boot_code_o, .espi_enable_o, .host_fw_periph_o,
		.se_fw_target_o, .flash_target_attached_o, .boot_code_reserved_o);
	bscfg_flash_model flash (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .lat_i(lat_m), .blk_i(blk_m),
		.flash_req_i(flash_req_o), .flash_addr_i(flash_addr_o), .flash_rdata_o(flash_rdata_i),
		.flash_rvalid_o(flash_rvalid_i));
	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Only the top two blocks of the 24-bit space are swapped
	function automatic logic [23:0] swapped(input logic [23:0] ad, input logic [2:0] b, input logic on);
		logic [23:0] m;
		m = 24'hFFFFFF << (17 + b);
		if (on && ((ad & m) == m))
			return ad ^ (24'h000001 << (16 + b));
		return ad;
	endfunction : swapped
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : tick
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_rd.push_back(e);
		@(posedge core_clk_i);
		reg_addr_i <= ad;
		reg_re_i <= 1'b1;
		@(posedge core_clk_i);
		reg_re_i <= 1'b0;
	endtask : rd
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge core_clk_i);
		reg_we_i <= 1'b0;
	endtask : wr
	task automatic hq(input logic [23:0] ad, input logic [23:0] e);
		exp_fa.push_back({8'h00, e});
		@(posedge core_clk_i);
		host_req_i <= 1'b1;
		host_addr_i <= ad;
		@(posedge core_clk_i);
		host_req_i <= 1'b0;
	endtask : hq
	task automatic wd(input logic e);
		@(posedge core_clk_i);
		watchdog_timer_expire_i <= 1'b1;
		@(posedge core_clk_i);
		watchdog_timer_expire_i <= 1'b0;
		#1;
		check(system_reboot_o, e);
		tick(1);
		check(system_reboot_o, 1'b0);
	endtask : wd
	task automatic core_cycle(input logic sw, input logic nr);
		@(posedge core_clk_i);
		core_power_good_i <= 1'b0;
		tick(2);
		check(strap_pulldown_en_o[1:0], 2'b11);
		@(posedge core_clk_i);
		{swap_override_strap_pin_i, no_reboot_strap_pin_i} <= {sw, nr};
		core_power_good_i <= 1'b1;
		// Pins go back to normal use and toggle freely
		@(posedge core_clk_i);
		{swap_override_strap_pin_i, no_reboot_strap_pin_i} <= ~{sw, nr};
		tick(2);
		check(strap_pulldown_en_o[1:0], 2'b00);
		check(strap_pin_normal_o[1:0], 2'b11);
		st_swap = sw;
		st_nrb = nr;
		swap_bit = swap_bit | sw;
	endtask : core_cycle
	task automatic res_cycle(input logic [3:0] c, input logic t, input logic [2:0] b, input logic [3:0] l);
		// Let a late host answer drain so it is not taken as a soft-strap word
		repeat (10) @(posedge core_clk_i);
		blk_m <= b;
		lat_m <= l;
		resume_reset_n_i <= 1'b0;
		tick(2);
		check(security_engine_reset_n_o, 1'b0);
		check(strap_pulldown_en_o[6:2], 5'h1F);
		for (int i = 0; i < SOFT_WORDS; i++)
			exp_fa.push_back({8'h00, SADDR + 24'(4 * i)});
		n_rv = 0;
		@(posedge core_clk_i);
		{boot_code_bit3_pin_i, boot_code_bit2_pin_i, boot_code_bit1_pin_i, boot_code_bit0_pin_i} <= c;
		transport_security_strap_pin_i <= t;
		resume_reset_n_i <= 1'b1;
		@(posedge core_clk_i);
		{boot_code_bit3_pin_i, boot_code_bit2_pin_i, boot_code_bit1_pin_i, boot_code_bit0_pin_i} <= ~c;
		transport_security_strap_pin_i <= ~t;
		tick(2);
		check(strap_pin_normal_o[6:2], 5'h1F);
		check(strap_pulldown_en_o[6:2], 5'h00);
		check(security_engine_reset_n_o, 1'b0);
		for (int k = 0; k < 300 && security_engine_reset_n_o !== 1'b1; k++)
			tick(1);
		check(32'(n_rv), 32'(SOFT_WORDS));
		check(host_reset_n_o, 1'b1);
	endtask : res_cycle
	task tally_and_finish;
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	//------------------------------------------------------------------
	// Clock, monitor and watchdog
	//------------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (rd_due)
			check(reg_rdata_o, exp_rd.size() ? exp_rd.pop_front() : 32'hDEAD_BEEF);
		rd_due = reg_re_i;
		if (flash_req_o === 1'b1)
			check({8'h00, flash_addr_o}, exp_fa.size() ? exp_fa.pop_front() : 32'hFFFF_FFFF);
		if (flash_rvalid_i === 1'b1)
			n_rv++;
	end
	initial begin
		repeat (30000) @(posedge core_clk_i);
		n_mismatch++;
		tally_and_finish;
	end
	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		{rstn_i, resume_reset_n_i, core_power_good_i, reg_we_i, reg_re_i, host_req_i, rd_due} = '0;
		{swap_override_strap_pin_i, no_reboot_strap_pin_i, transport_security_strap_pin_i} = '0;
		{boot_code_bit0_pin_i, boot_code_bit1_pin_i, boot_code_bit2_pin_i, boot_code_bit3_pin_i} = '0;
		{watchdog_timer_expire_i, swap_bit, st_swap, st_nrb} = '0;
		{deep_sleep_power_good_i, rtc_well_reset_n_i, platform_reset_n_i} = 3'h7;
		{reg_addr_i, reg_wdata_i, host_addr_i, blk_m} = '0;
		lat_m = 4'h1;
		seed = 32'hB07E7DF3;
		{n_mismatch, num_checks, n_rv} = '0;
		repeat (8) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		tick(1);
		check(strap_pulldown_en_o, 7'h7F);
		check(security_engine_reset_n_o, 1'b0);
		rd(REG_SWAP_OFS, 32'h0);
		rd(8'h40, 32'h0);
		core_cycle(1'b1, 1'b1);
		wd(1'b0);
		rd(REG_STAT_OFS, 32'h81);
		wr(REG_SWAP_OFS, 32'h0);
		rd(REG_SWAP_OFS, 32'h10);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			code = CODES[i];
			tr = r[0];
			res_cycle(code, tr, 3'(i), r[1] ? 4'h6 : 4'h1);
			vld = code inside {4'h0, 4'h2, 4'h4, 4'h8, 4'hC};
			check(boot_code_o, code);
			check(encrypted_transport_en_o, tr);
			check(espi_enable_o, vld && code != 4'h2);
			check(host_fw_periph_o, code == 4'h4 || code == 4'hC);
			check(se_fw_target_o, code == 4'h8 || code == 4'hC);
			check(flash_target_attached_o, code == 4'h8);
			check(boot_code_reserved_o, !vld);
			rd(REG_STAT_OFS, {24'h0, st_swap, 1'b1, code, tr, st_nrb});
			for (int j = 0; j < 2; j++) begin
				a = 24'(rnd());
				if (j == 0)
					a[23:16] = 8'hFF;
				hq(a, swapped(a, 3'(i), 1'b1));
			end
		end
		for (int i = 0; i < SOFT_WORDS; i++)
			rd(REG_SOFT_OFS + 8'(4 * i), {SADDR + 24'(4 * i), 5'h00, 3'h7});
		core_cycle(1'b0, 1'b0);
		wd(1'b1);
		wr(REG_SWAP_OFS, 32'h0);
		rd(REG_SWAP_OFS, 32'h0);
		hq(24'hFFFFF0, 24'hFFFFF0);
		wr(REG_SWAP_OFS, 32'h10);
		hq(24'hFF1234, 24'h7F1234);
		@(posedge core_clk_i);
		platform_reset_n_i <= 1'b0;
		tick(2);
		check(host_reset_n_o, 1'b0);
		@(posedge core_clk_i);
		platform_reset_n_i <= 1'b1;
		rd(REG_SWAP_OFS, 32'h10);
		@(posedge core_clk_i);
		rtc_well_reset_n_i <= 1'b0;
		@(posedge core_clk_i);
		rtc_well_reset_n_i <= 1'b1;
		rd(REG_SWAP_OFS, 32'h0);
		repeat (4) @(posedge core_clk_i);
		tally_and_finish;
	end
endmodule : tb_bscfg_top
